//--- logic/mem_bus_if.sv
// request and answer wires between the port controller and its memory
`timescale 1ns/1ps
interface mem_bus_if;
   import pccard_port_pkg::*;
   logic       rd_req;
   logic       wr_req;
   mem_addr_t  addr;
   word_t      wdata;
   logic [1:0] byte_en;
   word_t      rdata;

   modport ctrl (output rd_req, output wr_req, output addr, output wdata,
                 output byte_en, input rdata);
   modport mem  (input rd_req, input wr_req, input addr, input wdata,
                 input byte_en, output rdata);
endinterface

//--- logic/pc_card_host_slave_port.sv
// card-bus memory-cycle slave port with strap capture and wait stretching
`timescale 1ns/1ps
//
// Overview of operation
// - a cycle opens on either card enable low, closes when both are high
// - low enable alone moves one byte on low lines, A0 picks even or odd
// - both enables low move a whole 16-bit word
// - high enable alone moves the odd byte on the upper lines
// - wait stays low until read data ready or write data taken
// - wait stays low until refresh arbitration grants the resource
// - straps are captured at reset release and select port behaviour
// - after reset only revision and misc registers answer
// - clearing misc bit 7 opens all registers; software does this first
// - word address never uses A0; lanes come from card enables and A0
// - 21 address inputs, only A8..A1 decoded, and 16 data lines, bytes swapped for an odd 8-bit transfer
// - memory/register select chooses display memory or registers
// - byte enables come from the two card enables and A0, strobes from OE and WE
// - wait drive strap high drives wait whenever the port is enabled, low only when selected
// - divide strap high halves the tick rate, which gates only the arbitration grant
module pc_card_host_slave_port
   import pccard_port_pkg::*;
#(
   parameter logic [7:0] REVISION_CODE = 8'h5A  // arbitrary value
)
(
   input  wire logic                 clk,
   input  wire logic                 sys_rst,
   input  wire logic [ADDR_W-1:0]    host_addr_in,
   input  wire logic [DATA_W-1:0]    host_data_in,
   output logic      [DATA_W-1:0]    host_data_out,
   output logic                      host_data_oe,
   input  wire logic                 mem_reg_sel,
   input  wire logic                 chip_select_n,
   input  wire logic                 low_byte_enable_n,
   input  wire logic                 high_byte_enable_n,
   input  wire logic                 read_strobe_n,
   input  wire logic                 write_strobe_n,
   input  wire logic                 bus_start_n,
   input  wire logic [3:0]           host_if_type_straps,
   input  wire logic                 clk_div_strap,
   input  wire logic                 wait_drive_strap,
   input  wire logic                 refresh_busy,
   output logic                      wait_n_out,
   output logic                      wait_n_oe,
   output logic                      host_owns_mem,
   output logic                      port_enabled
);
   import pccard_port_pkg::*;

   // ----------------------------------------------------------------
   // lane and steering helpers
   // ----------------------------------------------------------------
   function automatic logic [1:0] lanes(input logic ce1, input logic ce2, input logic a0);
      if (ce1 && ce2)
         lanes = 2'h3;
      else if (ce1)
         lanes = a0 ? 2'h2 : 2'h1;
      else if (ce2)
         lanes = 2'h2;
      else
         lanes = 2'h0;
   endfunction

   // odd byte of an 8-bit low-lane transfer swaps to/from the high lane
   function automatic word_t steer(input word_t d, input logic odd8);
      steer = odd8 ? {d[7:0], d[15:8]} : d;
   endfunction

   // ----------------------------------------------------------------
   // synchroniser, straps, divider
   // ----------------------------------------------------------------
   logic [SYNC_W-1:0] sync1_r, sync2_r;
   logic              strap_done_r, strap_ok_r, div_r, wait_drive_r, tick_r;
   logic              strap_done_nxt, strap_ok_nxt, div_nxt, wait_drive_nxt, tick_nxt;
   logic              sel_s, ce1_s, ce2_s, rd_s, wr_s, ce_any_s;

   assign sel_s    = !sync2_r[SY_CS];
   assign ce1_s    = !sync2_r[SY_CE1];
   assign ce2_s    = !sync2_r[SY_CE2];
   assign rd_s     = !sync2_r[SY_RD];
   assign wr_s     = !sync2_r[SY_WR];
   assign ce_any_s = ce1_s || ce2_s;

   always_comb
   begin
      strap_done_nxt = 1'b1;
      strap_ok_nxt   = strap_ok_r;
      div_nxt        = div_r;
      wait_drive_nxt = wait_drive_r;
      if (!strap_done_r)
      begin
         strap_ok_nxt   = (host_if_type_straps == IF_TYPE_CODE);
         div_nxt        = clk_div_strap;
         wait_drive_nxt = wait_drive_strap;
      end
      tick_nxt = div_r ? !tick_r : 1'b1;
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         sync1_r      <= SYNC_IDLE;
         sync2_r      <= SYNC_IDLE;
         strap_done_r <= 1'b0;
         strap_ok_r   <= 1'b0;
         div_r        <= 1'b0;
         wait_drive_r <= 1'b0;
         tick_r       <= 1'b0;
      end
      else
      begin
         sync1_r      <= {write_strobe_n, read_strobe_n, high_byte_enable_n,
                          low_byte_enable_n, chip_select_n};
         sync2_r      <= sync1_r;
         strap_done_r <= strap_done_nxt;
         strap_ok_r   <= strap_ok_nxt;
         div_r        <= div_nxt;
         wait_drive_r <= wait_drive_nxt;
         tick_r       <= tick_nxt;
      end
   end

   // ----------------------------------------------------------------
   // cycle controller
   // ----------------------------------------------------------------
   mem_bus_if mbus ();

   port_state_t state_r, state_nxt;
   logic        is_read_r, is_read_nxt, odd8_r, odd8_nxt, allow_r, allow_nxt;
   logic        word0_r, word0_nxt;
   logic [1:0]  be_r, be_nxt;
   mem_addr_t   addr_r, addr_nxt;
   logic [7:0]  misc_r, misc_nxt;
   word_t       dout_r, dout_nxt;
   logic        dout_oe_r, dout_oe_nxt, wait_n_r, wait_n_nxt, wait_oe_r, wait_oe_nxt;
   logic        own_r, own_nxt;
   word_t       wdata_s;

   assign wdata_s = steer(host_data_in, odd8_r);

   always_comb
   begin
      state_nxt   = state_r;
      is_read_nxt = is_read_r;
      odd8_nxt    = odd8_r;
      allow_nxt   = allow_r;
      word0_nxt   = word0_r;
      be_nxt      = be_r;
      addr_nxt    = addr_r;
      misc_nxt    = misc_r;
      dout_nxt    = dout_r;
      mbus.rd_req  = 1'b0;
      mbus.wr_req  = 1'b0;
      mbus.addr    = addr_r;
      mbus.wdata   = wdata_s;
      mbus.byte_en = be_r;
      case (state_r)
         ST_IDLE:
         begin
            if (strap_ok_r && sel_s && ce_any_s)
               state_nxt = ST_ARB;
         end
         ST_ARB:
         begin
            if (!ce_any_s)
               state_nxt = ST_IDLE;
            else if (tick_r && !refresh_busy && (rd_s || wr_s))
            begin
               state_nxt   = ST_ACCESS;
               is_read_nxt = rd_s;
               be_nxt      = lanes(ce1_s, ce2_s, host_addr_in[0]);
               odd8_nxt    = ce1_s && !ce2_s && host_addr_in[0];
               addr_nxt    = {mem_reg_sel, host_addr_in[8:1]};
               word0_nxt   = !mem_reg_sel && (host_addr_in[8:1] == REG_REVISION_OFS[8:1]);
               allow_nxt   = !misc_r[MISC_LOCK_BIT];
            end
         end
         ST_ACCESS:
         begin
            state_nxt = ST_DONE;
            if (is_read_r)
            begin
               if (word0_r)
                  dout_nxt = steer({misc_r, REVISION_CODE}, odd8_r);
               else if (allow_r)
               begin
                  mbus.rd_req = 1'b1;
                  state_nxt   = ST_READ;
               end
               else
                  dout_nxt = 16'h0000;
            end
            else if (word0_r)
            begin
               if (be_r[1])
                  misc_nxt = wdata_s[15:8];
            end
            else
               mbus.wr_req = allow_r;
         end
         ST_READ:
         begin
            dout_nxt  = steer(mbus.rdata, odd8_r);
            state_nxt = ST_DONE;
         end
         ST_DONE:
         begin
            if (!ce_any_s)
               state_nxt = ST_IDLE;
         end
         default:
            state_nxt = ST_IDLE;
      endcase
      wait_n_nxt  = !(state_nxt == ST_ARB || state_nxt == ST_ACCESS || state_nxt == ST_READ);
      wait_oe_nxt = strap_ok_r && (wait_drive_r || (sel_s && ce_any_s));
      // drive only in a selected read
      dout_oe_nxt = (state_nxt == ST_DONE) && is_read_nxt && rd_s && sel_s && ce_any_s;
      own_nxt     = (state_nxt == ST_ACCESS) || (state_nxt == ST_READ);
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         state_r   <= ST_IDLE;
         is_read_r <= 1'b0;
         odd8_r    <= 1'b0;
         allow_r   <= 1'b0;
         word0_r   <= 1'b0;
         be_r      <= 2'h0;
         addr_r    <= '0;
         misc_r    <= MISC_RESET;
         dout_r    <= 16'h0000;
         dout_oe_r <= 1'b0;
         wait_n_r  <= 1'b1;
         wait_oe_r <= 1'b0;
         own_r     <= 1'b0;
      end
      else
      begin
         state_r   <= state_nxt;
         is_read_r <= is_read_nxt;
         odd8_r    <= odd8_nxt;
         allow_r   <= allow_nxt;
         word0_r   <= word0_nxt;
         be_r      <= be_nxt;
         addr_r    <= addr_nxt;
         misc_r    <= misc_nxt;
         dout_r    <= dout_nxt;
         dout_oe_r <= dout_oe_nxt;
         wait_n_r  <= wait_n_nxt;
         wait_oe_r <= wait_oe_nxt;
         own_r     <= own_nxt;
      end
   end

   port_mem u_mem (
      .clk     (clk),
      .sys_rst (sys_rst),
      .bus     (mbus.mem)
   );

   assign host_data_out = dout_r;
   assign host_data_oe  = dout_oe_r;
   assign wait_n_out    = wait_n_r;
   assign wait_n_oe     = wait_oe_r;
   assign host_owns_mem = own_r;
   assign port_enabled  = strap_ok_r;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   sequence s_cycle_open;
      (state_r == ST_IDLE) ##1 (state_r == ST_ARB);
   endsequence

   a_wait_on_open: assert property (s_cycle_open |-> !wait_n_r)
      else $error("wait not low when cycle opened");
   a_wait_refresh_hold: assert property (
      (state_r == ST_ARB) && refresh_busy && ce_any_s |=> (state_r == ST_ARB) && !wait_n_r)
      else $error("refresh contention did not hold wait");
   a_cycle_close: assert property ((state_r == ST_DONE) && !ce_any_s |=> state_r == ST_IDLE)
      else $error("cycle did not close on enables high");
   a_data_drive_read: assert property (dout_oe_r |-> (state_r == ST_DONE) && is_read_r)
      else $error("data bus driven outside a read");
   a_word_lanes: assert property (
      (state_r == ST_ARB) && (state_nxt == ST_ACCESS) && ce1_s && ce2_s |=> be_r == 2'h3)
      else $error("word transfer lanes wrong");
   a_odd_high_lane: assert property (
      (state_r == ST_ARB) && (state_nxt == ST_ACCESS) && ce2_s && !ce1_s
      |=> be_r == 2'h2 && !odd8_r)
      else $error("odd byte not on upper lane");
   // address bit zero is judged as it stood at the decision edge
   a_byte_steer: assert property (
      (state_r == ST_ARB) && (state_nxt == ST_ACCESS) && ce1_s && !ce2_s
      |=> be_r == ($past(host_addr_in[0]) ? 2'h2 : 2'h1) && odd8_r == $past(host_addr_in[0]))
      else $error("eight-bit lane steering wrong");
   a_lock_blocks_mem: assert property (
      misc_r[MISC_LOCK_BIT] && (state_r == ST_ARB) ##1 (state_r == ST_ACCESS)
      |-> !mbus.wr_req && !mbus.rd_req)
      else $error("locked port reached memory");
   a_unlock_write: assert property (
      (state_r == ST_ACCESS) && !is_read_r && word0_r && be_r[1]
      |=> misc_r == $past(wdata_s[15:8]))
      else $error("misc write not taken");
   a_strap_capture: assert property (
      !strap_done_r |=> strap_done_r && div_r == $past(clk_div_strap)
      && wait_drive_r == $past(wait_drive_strap))
      else $error("straps not captured at release");
   a_wait_float: assert property (strap_done_r && !wait_drive_r && !sel_s |=> !wait_oe_r)
      else $error("wait driven while deselected");
   a_div_tick: assert property (div_r && tick_r |=> !tick_r)
      else $error("divided tick not halved");
endmodule

//--- logic/pccard_port_pkg.sv
// constants and types shared by the card-bus slave port and its memory
package pccard_port_pkg;
   // ----------------------------------------------------------------
   // register map (byte offsets in the register space)
   // ----------------------------------------------------------------
   localparam logic [8:0] REG_REVISION_OFS = 9'h000;
   localparam logic [8:0] REG_MISC_OFS     = 9'h001;
   localparam int         MISC_LOCK_BIT    = 7;
   localparam logic [7:0] MISC_RESET       = 8'h80;
   // ----------------------------------------------------------------
   // straps and widths
   // ----------------------------------------------------------------
   localparam logic [3:0] IF_TYPE_CODE     = 4'h9;
   localparam int         ADDR_W           = 21;
   localparam int         DATA_W           = 16;
   localparam int         MEM_AW           = 9;
   localparam int         SYNC_W           = 5;
   // positions inside the synchronised strobe vector (all active low)
   localparam int         SY_CS            = 0;
   localparam int         SY_CE1           = 1;
   localparam int         SY_CE2           = 2;
   localparam int         SY_RD            = 3;
   localparam int         SY_WR            = 4;
   localparam logic [SYNC_W-1:0] SYNC_IDLE = 5'h1F;

   typedef enum logic [2:0] {ST_IDLE, ST_ARB, ST_ACCESS, ST_READ, ST_DONE} port_state_t;
   typedef logic [MEM_AW-1:0] mem_addr_t;
   typedef logic [DATA_W-1:0] word_t;
endpackage

//--- logic/port_mem.sv
// small word memory with byte writes and a registered read port
`timescale 1ns/1ps
module port_mem
   import pccard_port_pkg::*;
(
   input  wire logic  clk,
   input  wire logic  sys_rst,
   mem_bus_if.mem     bus
);
   word_t mem_q [0:(1<<MEM_AW)-1];
   word_t rdata_r;
   word_t rdata_nxt;

   assign bus.rdata = rdata_r;

   always_comb
   begin
      rdata_nxt = rdata_r;
      if (bus.rd_req)
      begin
         rdata_nxt = mem_q[bus.addr];
      end
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         rdata_r <= 16'h0000;
      end
      else
      begin
         rdata_r <= rdata_nxt;
      end
   end

   // array has no reset: its contents are undefined until written
   always_ff @(posedge clk)
   begin
      if (bus.wr_req && bus.byte_en[0])
      begin
         mem_q[bus.addr][7:0] <= bus.wdata[7:0];
      end
      if (bus.wr_req && bus.byte_en[1])
      begin
         mem_q[bus.addr][15:8] <= bus.wdata[15:8];
      end
   end
endmodule

//--- verification/card_host_model.sv
// socket controller model that runs memory cycles on the card pins
`timescale 1ns/1ps
module card_host_model
   import pccard_port_pkg::*;
(
   input  wire logic              clk,
   output logic      [ADDR_W-1:0] host_addr_in,
   output logic      [DATA_W-1:0] host_data_in,
   input  wire logic [DATA_W-1:0] host_data_out,
   input  wire logic              host_data_oe,
   output logic                   mem_reg_sel,
   output logic                   chip_select_n,
   output logic                   low_byte_enable_n,
   output logic                   high_byte_enable_n,
   output logic                   read_strobe_n,
   output logic                   write_strobe_n,
   output logic                   bus_start_n,
   input  wire logic              wait_n_out,
   input  wire logic              wait_n_oe
);
   logic wait_pin;

   // the wait line has a pull-up, so an undriven pin reads high
   assign wait_pin = wait_n_oe ? wait_n_out : 1'b1;
   assign bus_start_n = 1'b1;

   initial
   begin
      host_addr_in = 21'h000000;
      host_data_in = 16'h0000;
      mem_reg_sel = 1'b0;
      chip_select_n = 1'b1;
      low_byte_enable_n = 1'b1;
      high_byte_enable_n = 1'b1;
      read_strobe_n = 1'b1;
      write_strobe_n = 1'b1;
   end

   // ----------------------------------------------------------------
   // one memory cycle; lanes bit0 = low enable, bit1 = high enable
   // ----------------------------------------------------------------
   task automatic access(input logic mem, input logic [ADDR_W-1:0] a, input logic [1:0] lanes,
                         input logic wr, input word_t wd, output word_t rd, output int waits,
                         output int lat, output logic ok);
      int n;
      logic seen;
      waits = 0;
      lat = 0;
      seen = 1'b0;
      ok = 1'b0;
      rd = 'x;
      @(posedge clk);
      #1;
      host_addr_in = a;
      mem_reg_sel = mem;
      chip_select_n = 1'b0;
      low_byte_enable_n = ~lanes[0];
      high_byte_enable_n = ~lanes[1];
      read_strobe_n = wr;
      write_strobe_n = ~wr;
      if (wr)
         host_data_in = wd;
      for (n = 0; n < 60 && !ok; n++)
      begin
         @(posedge clk);
         #1;
         if (wait_pin === 1'b0)
         begin
            waits++;
            seen = 1'b1;
         end
         else if (seen)
         begin
            ok = 1'b1;
            rd = (host_data_oe === 1'b1) ? host_data_out : 16'hXXXX;
         end
         else
            lat++;
      end
      low_byte_enable_n = 1'b1;
      high_byte_enable_n = 1'b1;
      chip_select_n = 1'b1;
      read_strobe_n = 1'b1;
      write_strobe_n = 1'b1;
      // released lines must not look like the last value
      host_data_in = ~host_data_in;
      host_addr_in = ~host_addr_in;
      repeat (4) @(posedge clk);
      // return off the edge so callers never sample or drive on it
      #1;
   endtask
endmodule

//--- verification/pc_card_host_slave_port_test.sv
// self-checking bench for the card-bus slave port
`timescale 1ns/1ps
module pc_card_host_slave_port_test;
   import pccard_port_pkg::*;
   localparam logic [7:0] REV_CODE = 8'h3C;  // arbitrary value
   logic              clk, sys_rst, refresh_busy, clk_div_strap, wait_drive_strap;
   logic [3:0]        host_if_type_straps;
   logic [ADDR_W-1:0] host_addr_in;
   word_t             host_data_in, host_data_out, rd;
   logic              host_data_oe, mem_reg_sel, chip_select_n, low_byte_enable_n;
   logic              high_byte_enable_n, read_strobe_n, write_strobe_n, bus_start_n;
   logic              wait_n_out, wait_n_oe, host_owns_mem, port_enabled, ok;
   int                err_total, checked, waits, lat;

   pc_card_host_slave_port #(.REVISION_CODE(REV_CODE)) i_dut (.clk(clk), .sys_rst(sys_rst),
      .host_addr_in(host_addr_in), .host_data_in(host_data_in), .host_data_out(host_data_out),
      .host_data_oe(host_data_oe), .mem_reg_sel(mem_reg_sel), .chip_select_n(chip_select_n),
      .low_byte_enable_n(low_byte_enable_n), .high_byte_enable_n(high_byte_enable_n),
      .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
      .bus_start_n(bus_start_n), .host_if_type_straps(host_if_type_straps),
      .clk_div_strap(clk_div_strap), .wait_drive_strap(wait_drive_strap),
      .refresh_busy(refresh_busy), .wait_n_out(wait_n_out), .wait_n_oe(wait_n_oe),
      .host_owns_mem(host_owns_mem), .port_enabled(port_enabled));

   card_host_model i_host (.clk(clk), .host_addr_in(host_addr_in),
      .host_data_in(host_data_in), .host_data_out(host_data_out), .host_data_oe(host_data_oe),
      .mem_reg_sel(mem_reg_sel), .chip_select_n(chip_select_n),
      .low_byte_enable_n(low_byte_enable_n), .high_byte_enable_n(high_byte_enable_n),
      .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
      .bus_start_n(bus_start_n), .wait_n_out(wait_n_out), .wait_n_oe(wait_n_oe));

   // port clock on its own input
   always #50 clk = ~clk;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task automatic test_done();
      $display("checks=%0d errors=%0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic chk(input word_t got, input word_t exp);
      checked++;
      if (got !== exp)
      begin
         err_total++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic acc(input logic mem, input logic [ADDR_W-1:0] a, input logic [1:0] lanes,
                      input logic wr, input word_t wd);
      i_host.access(mem, a, lanes, wr, wd, rd, waits, lat, ok);
   endtask

   task automatic do_reset(input logic [3:0] straps, input logic div, input logic wdrv);
      @(posedge clk);
      #1;
      host_if_type_straps = straps;
      clk_div_strap = div;
      wait_drive_strap = wdrv;
      sys_rst = 1'b1;
      repeat (5) @(posedge clk);
      #1;
      sys_rst = 1'b0;
      repeat (3) @(posedge clk);
      #1;
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_reset();
      chk({15'h0, port_enabled}, 16'h0001);
      chk({14'h0, host_data_oe, host_owns_mem}, 16'h0000);
      chk({14'h0, wait_n_out, wait_n_oe}, 16'h0003);
   endtask

   task automatic t_lock();
      acc(1'b0, 21'h000000, 2'b11, 1'b0, 16'h0000);
      chk(rd, {MISC_RESET, REV_CODE});
      chk(waits[15:0], 16'h0002);
      acc(1'b0, 21'h000004, 2'b11, 1'b1, 16'h1234);
      acc(1'b0, 21'h000004, 2'b11, 1'b0, 16'h0000);
      chk(rd, 16'h0000);
      acc(1'b1, 21'h000020, 2'b11, 1'b0, 16'h0000);
      chk({15'h0, ok}, 16'h0001);
      chk(rd, 16'h0000);
   endtask

   task automatic t_unlock();
      acc(1'b0, 21'h000001, 2'b10, 1'b1, 16'h03FF);
      acc(1'b0, 21'h000000, 2'b11, 1'b0, 16'h0000);
      chk(rd, {8'h03, REV_CODE});
      acc(1'b0, 21'h000001, 2'b01, 1'b0, 16'h0000);
      chk({8'h00, rd[7:0]}, 16'h0003);
      acc(1'b0, 21'h000000, 2'b01, 1'b1, 16'h00FF);
      acc(1'b0, 21'h000000, 2'b01, 1'b0, 16'h0000);
      chk({8'h00, rd[7:0]}, {8'h00, REV_CODE});
      acc(1'b0, 21'h000001, 2'b10, 1'b0, 16'h0000);
      chk({8'h00, rd[15:8]}, 16'h0003);
   endtask

   task automatic t_regs();
      acc(1'b0, 21'h000004, 2'b11, 1'b1, 16'hA5C3);
      acc(1'b0, 21'h000005, 2'b11, 1'b0, 16'h0000);
      chk(rd, 16'hA5C3);
      chk(lat[15:0], 16'h0002);
      chk(waits[15:0], 16'h0003);
      chk({15'h0, host_data_oe}, 16'h0000);
   endtask

   task automatic t_mem();
      refresh_busy = 1'b1;
      fork
         acc(1'b1, 21'h000010, 2'b11, 1'b1, 16'h5AA5);
         begin
            repeat (12) @(posedge clk);
            #1;
            chk({15'h0, host_owns_mem}, 16'h0000);
            refresh_busy = 1'b0;
            @(posedge clk);
            #1;
            chk({15'h0, host_owns_mem}, 16'h0001);
         end
      join
      chk({15'h0, waits >= 8}, 16'h0001);
      acc(1'b1, 21'h000010, 2'b11, 1'b0, 16'h0000);
      chk(rd, 16'h5AA5);
      acc(1'b1, 21'h000011, 2'b01, 1'b0, 16'h0000);
      chk({8'h00, rd[7:0]}, 16'h005A);
   endtask

   task automatic t_straps();
      do_reset(4'h8, 1'b0, 1'b1);
      chk({15'h0, port_enabled}, 16'h0000);
      acc(1'b0, 21'h000000, 2'b11, 1'b0, 16'h0000);
      chk({15'h0, ok}, 16'h0000);
      do_reset(IF_TYPE_CODE, 1'b1, 1'b0);
      chk({15'h0, wait_n_oe}, 16'h0000);
      // one idle edge lands the cycle open on the slow tick phase
      @(posedge clk);
      acc(1'b0, 21'h000000, 2'b11, 1'b0, 16'h0000);
      chk(rd, {MISC_RESET, REV_CODE});
      chk(waits[15:0], 16'h0003);
   endtask

   // ----------------------------------------------------------------
   // main sequence and watchdog
   // ----------------------------------------------------------------
   initial
   begin
      clk = 1'b0;
      sys_rst = 1'b1;
      refresh_busy = 1'b0;
      host_if_type_straps = IF_TYPE_CODE;
      clk_div_strap = 1'b0;
      wait_drive_strap = 1'b1;
      err_total = 0;
      checked = 0;
      do_reset(IF_TYPE_CODE, 1'b0, 1'b1);
      t_reset();
      t_lock();
      t_unlock();
      t_regs();
      t_mem();
      t_straps();
      test_done();
   end

   // the whole run needs well under a thousand cycles
   initial
   begin
      #400000;
      err_total++;
      test_done();
   end
endmodule
